// File: design/tag_config_register_bank.sv
/*
  Configuration and session register bank of a dual-interface tag, with the
  field-detect open-drain pin. Host side runs on clock; RF side on rf_clock.
  Assumes RF events and RF write requests are spaced by at least four rf_clock
  cycles, and the host last-data strobes are one-cycle pulses on clock; data ready may stay high as a level.
*/
// What this block does
// - Select 00: pin low on field on
// - Select 01: pin low on first SoC
// - Select 10: pin low on tag selection
// - Select 11, RF-to-host: low on data ready
// - Select 11, host-to-RF: low when RF read
// - Mirror enable maps buffer at mirror base
// - Direction bit picks flow, resets to 1
// - RF read of last page sets flag
// - Watchdog is 16 bits, resets 0848h
// - High byte write loads both; low alone waits
// - Clock-stretch bit 0 enables stretching, resets 1
// - Host lock rejects host configuration writes, sticky
// - RF lock rejects RF changes, sticky
// - Reset copies configuration into session registers
// - Pass-through enable bit turns mode on
// - Message flag clears when read
`timescale 1ns/100ps
`default_nettype none
`include "tag_cfg_defines.svh"

module tag_config_register_bank #(
  parameter int unsigned LAST_BLOCK_MAX = 127
) (
  // Host clock domain
  input  wire logic                   clock,
  input  wire logic                   srst,
  // Host register port
  input  wire tag_cfg_pkg::host_req_t host_req,
  output logic                        host_rsp_valid,
  output logic [7:0]                  host_rsp_data,
  // Host-side pass-through events
  input  wire tag_cfg_pkg::host_events_t host_ev,
  // RF link domain
  input  wire logic                   rf_clock,
  input  wire logic                   rf_srst,
  input  wire tag_cfg_pkg::rf_req_t   rf_req,
  output logic                        rf_req_ready,
  input  wire tag_cfg_pkg::rf_events_t rf_ev,
  // Field-detect open-drain pin
  input  wire logic                   field_detect_in,
  output logic                        field_detect_output,
  output logic                        field_detect_oe_n,
  // Session configuration outputs
  output logic                        passthrough_enable,
  output logic                        transfer_dir,
  output logic                        mirror_enable,
  output logic [7:0]                  mirror_base_block,
  output logic [15:0]                 watchdog_time,
  output logic                        clock_stretch_enable,
  output logic                        rf_mem_write_refused
);
  import tag_cfg_pkg::*;

  if (LAST_BLOCK_MAX < 1 || LAST_BLOCK_MAX > 255) begin : g_chk
    $error("LAST_BLOCK_MAX must lie in 1..255");
  end

  // ****************************************
  // RF link side
  // ****************************************
  rf_state_t   rs, rs_next;
  main_state_t r, r_next;

  always_comb begin
    rs_next          = rs;
    rs_next.ack_sync = {rs.ack_sync[0], r.ack_tog};
    if (rs.st == RF_BUSY && rs.ack_sync[1] == rs.tog[`TOG_REQ]) begin
      rs_next.st    = RF_IDLE;
      rs_next.ready = 1'b1;
    end
    // Address and data stay put until acknowledged, so the host side may read them
    if (rs.st == RF_IDLE && rf_req.valid) begin
      rs_next.st             = RF_BUSY;
      rs_next.ready          = 1'b0;
      rs_next.addr           = rf_req.addr;
      rs_next.data           = rf_req.wdata;
      rs_next.tog[`TOG_REQ]  = ~rs.tog[`TOG_REQ];
    end
    if (rf_ev.soc)
      rs_next.tog[`TOG_SOC] = ~rs.tog[`TOG_SOC];
    if (rf_ev.select)
      rs_next.tog[`TOG_SELECT] = ~rs.tog[`TOG_SELECT];
    if (rf_ev.halt)
      rs_next.tog[`TOG_HALT] = ~rs.tog[`TOG_HALT];
    if (rf_ev.read) begin
      rs_next.page           = rf_ev.read_page;
      rs_next.tog[`TOG_READ] = ~rs.tog[`TOG_READ];
    end
    if (rf_ev.pt_read_done)
      rs_next.tog[`TOG_PTDONE] = ~rs.tog[`TOG_PTDONE];
  end

  always_ff @(posedge rf_clock) begin
    if (rf_srst) begin
      rs       <= '0;
      rs.st    <= RF_IDLE;
      rs.ready <= 1'b1;
    end else begin
      rs <= rs_next;
    end
  end

  // ****************************************
  // Host side decode
  // ****************************************
  logic [`TOG_W-1:0] ev;
  logic [1:0]        asel;
  logic [1:0]        rsel;
  logic              field_now;
  logic              field_rise;
  logic              field_fall;
  logic              msg_hit;
  logic              pt_ready_rise;
  logic              assert_ev;
  logic              release_ev;

  assign ev            = r.tog_s2 ^ r.tog_s3;
  assign asel          = r.ses[`IDX_CTRL][`CTRL_ASRT_HI:`CTRL_ASRT_LO];
  assign rsel          = r.ses[`IDX_CTRL][`CTRL_REL_HI:`CTRL_REL_LO];
  assign field_now     = r.field_sync[1];
  assign field_rise    = field_now & ~r.field_prev;
  assign field_fall    = ~field_now & r.field_prev;
  assign pt_ready_rise = host_ev.pt_data_ready & ~r.pt_ready_prev;
  // Last page of a four-page block
  assign msg_hit = ev[`TOG_READ] && r.ses[`IDX_LAST] != 8'h00 &&
                   {2'b00, r.ses[`IDX_LAST]} <= 10'(LAST_BLOCK_MAX) &&
                   {1'b0, rs.page} == {r.ses[`IDX_LAST], 2'b11};

  always_comb begin
    case (asel)
      `SEL_FIELD:  assert_ev = field_rise;
      `SEL_SOC:    assert_ev = ev[`TOG_SOC];
      `SEL_SELECT: assert_ev = ev[`TOG_SELECT];
      default:     assert_ev = r.ses[`IDX_CTRL][`CTRL_PT_BIT] &
                               (r.ses[`IDX_CTRL][`CTRL_DIR_BIT] ? pt_ready_rise
                                                                : ev[`TOG_PTDONE]);
    endcase
  end

  assign release_ev = field_fall |
                      (rsel == `REL_HALT && ev[`TOG_HALT]) |
                      (rsel == `REL_LAST && msg_hit) |
                      (rsel == `REL_PT && asel == `SEL_PT && r.ses[`IDX_CTRL][`CTRL_PT_BIT] &&
                       (r.ses[`IDX_CTRL][`CTRL_DIR_BIT] ? host_ev.pt_last_read
                                                        : host_ev.pt_last_written));

  // Configuration byte update: lock bits only set, reserved bits of the lock and stretch bytes stay zero
  function automatic logic [7:0] cfg_merge(input logic [2:0] idx, input logic [7:0] old,
                                           input logic [7:0] data);
    logic [7:0] res;
    res = data;
    if (idx == `IDX_LOCK)
      res = old | {6'h00, data[`LOCK_HOST_BIT:`LOCK_RF_BIT]};
    else if (idx == `IDX_STRETCH)
      res = {7'h00, data[`STRETCH_BIT]};
    return res;
  endfunction

  // ****************************************
  // Host side state update
  // ****************************************
  always_comb begin
    r_next               = r;
    r_next.field_sync    = {r.field_sync[0], rf_ev.field_on};
    r_next.field_prev    = r.field_sync[1];
    r_next.pin_sync      = {r.pin_sync[0], field_detect_in};
    r_next.tog_s1        = rs.tog;
    r_next.tog_s2        = r.tog_s1;
    r_next.tog_s3        = r.tog_s2;
    r_next.pt_ready_prev = host_ev.pt_data_ready;
    r_next.rsp_valid     = 1'b0;

    // One cycle after reset the stored configuration becomes the session copy
    if (r.load_pending) begin
      r_next.load_pending = 1'b0;
      for (int i = 0; i < 6; i++)
        r_next.ses[i] = r.cfg[i];
      r_next.wdt_active = {r.cfg[`IDX_WDT_HI], r.cfg[`IDX_WDT_LO]};
    end

    if (host_req.valid) begin
      r_next.rsp_valid = 1'b1;
      if (!host_req.session)
        r_next.rsp_data = (host_req.addr <= `IDX_LOCK) ? r.cfg[host_req.addr] : 8'h00;
      else if (host_req.addr < `IDX_STATUS)
        r_next.rsp_data = r.ses[host_req.addr];
      else if (host_req.addr == `IDX_STATUS)
        r_next.rsp_data = {r.msg_read, r.pin_sync[1], 5'h00, field_now};
      else
        r_next.rsp_data = 8'h00;
      if (!host_req.write && host_req.session && host_req.addr == `IDX_STATUS)
        r_next.msg_read = 1'b0;
      if (host_req.write && !host_req.session && host_req.addr <= `IDX_LOCK &&
          !r.cfg[`IDX_LOCK][`LOCK_HOST_BIT]) begin
        r_next.cfg[host_req.addr] = cfg_merge(host_req.addr, r.cfg[host_req.addr],
                                              host_req.wdata);
        if (host_req.addr == `IDX_WDT_HI)
          r_next.wdt_active = {host_req.wdata, r.cfg[`IDX_WDT_LO]};
      end
      // Session clock-stretch byte is read-only through the host
      if (host_req.write && host_req.session && host_req.addr <= `IDX_WDT_HI) begin
        r_next.ses[host_req.addr] = host_req.wdata;
        if (host_req.addr == `IDX_WDT_HI)
          r_next.wdt_active = {host_req.wdata, r.ses[`IDX_WDT_LO]};
      end
    end

    // RF writes reach only the stored configuration, plus the active watchdog on a high byte write
    if (ev[`TOG_REQ]) begin
      r_next.ack_tog = r.tog_s2[`TOG_REQ];
      if (rs.addr <= `IDX_LOCK && !r.cfg[`IDX_LOCK][`LOCK_RF_BIT]) begin
        r_next.cfg[rs.addr] = cfg_merge(rs.addr, r_next.cfg[rs.addr], rs.data);
        if (rs.addr == `IDX_WDT_HI)
          r_next.wdt_active = {rs.data, r_next.cfg[`IDX_WDT_LO]};
      end
    end

    // Set is evaluated last so a read-clear in the same cycle does not lose it
    if (msg_hit)
      r_next.msg_read = 1'b1;

    case (r.fd_state)
      FD_RELEASED: begin
        if (assert_ev && !release_ev) begin
          r_next.fd_state = FD_LOW;
          r_next.fd_oe_n  = 1'b0;
        end
      end
      FD_LOW: begin
        if (release_ev) begin
          r_next.fd_state = FD_RELEASED;
          r_next.fd_oe_n  = 1'b1;
        end
      end
      default: begin
        r_next.fd_state = FD_RELEASED;
        r_next.fd_oe_n  = 1'b1;
      end
    endcase

    r_next.fd_drive    = 1'b0;
    r_next.rf_wr_block = ~r_next.ses[`IDX_CTRL][`CTRL_DIR_BIT];
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      r                    <= '0;
      r.cfg[`IDX_CTRL]     <= `RST_CTRL;
      r.cfg[`IDX_LAST]     <= `RST_LAST;
      r.cfg[`IDX_MIRROR]   <= `RST_MIRROR;
      r.cfg[`IDX_WDT_LO]   <= `RST_WDT_LO;
      r.cfg[`IDX_WDT_HI]   <= `RST_WDT_HI;
      r.cfg[`IDX_STRETCH]  <= `RST_STRETCH;
      r.cfg[`IDX_LOCK]     <= `RST_LOCK;
      r.fd_state           <= FD_RELEASED;
      r.fd_oe_n            <= 1'b1;
      r.load_pending       <= 1'b1;
    end else begin
      r <= r_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign host_rsp_valid       = r.rsp_valid;
  assign host_rsp_data        = r.rsp_data;
  assign rf_req_ready         = rs.ready;
  assign field_detect_output  = r.fd_drive;
  assign field_detect_oe_n    = r.fd_oe_n;
  assign passthrough_enable   = r.ses[`IDX_CTRL][`CTRL_PT_BIT];
  assign transfer_dir         = r.ses[`IDX_CTRL][`CTRL_DIR_BIT];
  assign mirror_enable        = r.ses[`IDX_CTRL][`CTRL_MIRROR_BIT];
  assign mirror_base_block    = r.ses[`IDX_MIRROR];
  assign watchdog_time        = r.wdt_active;
  assign clock_stretch_enable = r.ses[`IDX_STRETCH][`STRETCH_BIT];
  assign rf_mem_write_refused = r.rf_wr_block;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_released_quiet;
    r.fd_state == FD_RELEASED && !release_ev;
  endsequence

  sequence s_host_ses_write(logic [2:0] idx);
    host_req.valid && host_req.write && host_req.session && host_req.addr == idx &&
    !ev[`TOG_REQ] && !r.load_pending;
  endsequence

  AST_ASSERT_FIELD: assert property (s_released_quiet ##0 (asel == `SEL_FIELD && field_rise)
    |=> !field_detect_oe_n) else $error("pin not low after field on");
  AST_ASSERT_SOC: assert property (s_released_quiet ##0 (asel == `SEL_SOC && ev[`TOG_SOC])
    |=> !field_detect_oe_n) else $error("pin not low after start of communication");
  AST_ASSERT_SELECT: assert property (s_released_quiet ##0 (asel == `SEL_SELECT &&
    ev[`TOG_SELECT]) |=> !field_detect_oe_n) else $error("pin not low after select");
  AST_ASSERT_PT_HOST: assert property (s_released_quiet ##0 (asel == `SEL_PT &&
    passthrough_enable && transfer_dir && pt_ready_rise) |=> !field_detect_oe_n)
    else $error("pin not low on data ready");
  AST_FD_HOLD: assert property (r.fd_state == FD_LOW && !release_ev |=> !field_detect_oe_n)
    else $error("pin released without release event");
  AST_MSG_SET: assert property (msg_hit |=> r.msg_read [*1] ##1 1'b1)
    else $error("message flag not set on last page read");
  AST_MSG_CLEAR: assert property (host_req.valid && !host_req.write && host_req.session &&
    host_req.addr == `IDX_STATUS && !msg_hit |=> !r.msg_read)
    else $error("message flag not cleared on read");
  AST_WDT_LOAD: assert property (s_host_ses_write(`IDX_WDT_HI) |=>
    watchdog_time == {$past(host_req.wdata), $past(r.ses[`IDX_WDT_LO])})
    else $error("watchdog not loaded from both bytes");
  AST_WDT_LOW_ONLY: assert property (s_host_ses_write(`IDX_WDT_LO) |=> $stable(watchdog_time))
    else $error("low byte write changed watchdog");
  AST_LOCK_STICKY: assert property (r.cfg[`IDX_LOCK][`LOCK_HOST_BIT] |=>
    r.cfg[`IDX_LOCK][`LOCK_HOST_BIT] && $stable(r.cfg[`IDX_LOCK][`LOCK_HOST_BIT]))
    else $error("host lock bit cleared");
  AST_HOST_LOCKED: assert property (host_req.valid && host_req.write && !host_req.session &&
    r.cfg[`IDX_LOCK][`LOCK_HOST_BIT] && !ev[`TOG_REQ] |=> $stable(r.cfg))
    else $error("locked host write changed configuration");
  AST_LOAD: assert property (r.load_pending && !host_req.valid |=>
    r.ses[`IDX_CTRL] == $past(r.cfg[`IDX_CTRL]) && watchdog_time == 16'h0848)
    else $error("session copy not loaded after reset");
  AST_ASSERT_PT_RF: assert property (s_released_quiet ##0 (asel == `SEL_PT &&
    passthrough_enable && !transfer_dir && ev[`TOG_PTDONE]) |=> !field_detect_oe_n)
    else $error("pin not low after RF side read");
  AST_RF_LOCK_STICKY: assert property (r.cfg[`IDX_LOCK][`LOCK_RF_BIT] |=>
    r.cfg[`IDX_LOCK][`LOCK_RF_BIT]) else $error("RF lock bit cleared");
  // Halt release is the only path that needs the RF halt toggle
  AST_HALT_RELEASE: assert property (r.fd_state == FD_LOW && rsel == `REL_HALT &&
    ev[`TOG_HALT] |=> field_detect_oe_n) else $error("pin not released on halt");

endmodule // tag_config_register_bank
`default_nettype wire

// File: shared/tag_cfg_defines.svh
/*
  Offsets, field positions, reset values and codes of the tag configuration bank.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef TAG_CFG_DEFINES_SVH
`define TAG_CFG_DEFINES_SVH

// ****************************************
// Register indices (byte position in bank)
// ****************************************
`define IDX_CTRL        3'h0
`define IDX_LAST        3'h1
`define IDX_MIRROR      3'h2
`define IDX_WDT_LO      3'h3
`define IDX_WDT_HI      3'h4
`define IDX_STRETCH     3'h5
`define IDX_LOCK        3'h6
`define IDX_STATUS      3'h6

// ****************************************
// Reset values
// ****************************************
`define RST_CTRL        8'h01
`define RST_LAST        8'h00
`define RST_MIRROR      8'hf8
`define RST_WDT_LO      8'h48
`define RST_WDT_HI      8'h08
`define RST_STRETCH     8'h01
`define RST_LOCK        8'h00

// ****************************************
// Field positions
// ****************************************
`define CTRL_PT_BIT     6
`define CTRL_REL_HI     5
`define CTRL_REL_LO     4
`define CTRL_ASRT_HI    3
`define CTRL_ASRT_LO    2
`define CTRL_MIRROR_BIT 1
`define CTRL_DIR_BIT    0
`define STRETCH_BIT     0
`define LOCK_HOST_BIT   1
`define LOCK_RF_BIT     0
`define STATUS_MSG_BIT  7
`define STATUS_PIN_BIT  6
`define STATUS_FLD_BIT  0

// ****************************************
// Event select codes
// ****************************************
`define SEL_FIELD       2'h0
`define SEL_SOC         2'h1
`define SEL_SELECT      2'h2
`define SEL_PT          2'h3
`define REL_HALT        2'h1
`define REL_LAST        2'h2
`define REL_PT          2'h3

// ****************************************
// Crossing toggle slots and widths
// ****************************************
`define TOG_REQ         0
`define TOG_SOC         1
`define TOG_SELECT      2
`define TOG_HALT        3
`define TOG_READ        4
`define TOG_PTDONE      5
`define TOG_W           6
`define PAGE_W          9

`endif

// File: shared/tag_cfg_pkg.sv
/*
  Types of the tag configuration bank: carriers, state machines and state structs.
  Assumes tag_cfg_defines.svh is on the include path.
*/
`include "tag_cfg_defines.svh"

package tag_cfg_pkg;

  typedef enum logic [1:0] {FD_RELEASED = 2'b01, FD_LOW = 2'b10} fd_state_t;
  typedef enum logic [1:0] {RF_IDLE = 2'b01, RF_BUSY = 2'b10} rf_fsm_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       session;
    logic [2:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic       pt_data_ready;
    logic       pt_last_read;
    logic       pt_last_written;
  } host_events_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] addr;
    logic [7:0] wdata;
  } rf_req_t;

  typedef struct packed {
    logic                field_on;
    logic                soc;
    logic                select;
    logic                halt;
    logic                read;
    logic [`PAGE_W-1:0]  read_page;
    logic                pt_read_done;
  } rf_events_t;

  typedef struct packed {
    rf_fsm_t             st;
    logic                ready;
    logic [`TOG_W-1:0]   tog;
    logic [2:0]          addr;
    logic [7:0]          data;
    logic [`PAGE_W-1:0]  page;
    logic [1:0]          ack_sync;
  } rf_state_t;

  typedef struct packed {
    logic [6:0][7:0]     cfg;
    logic [5:0][7:0]     ses;
    logic [15:0]         wdt_active;
    logic                msg_read;
    fd_state_t           fd_state;
    logic                fd_drive;
    logic                fd_oe_n;
    logic                load_pending;
    logic                rsp_valid;
    logic [7:0]          rsp_data;
    logic                rf_wr_block;
    logic [1:0]          field_sync;
    logic                field_prev;
    logic [1:0]          pin_sync;
    logic [`TOG_W-1:0]   tog_s1;
    logic [`TOG_W-1:0]   tog_s2;
    logic [`TOG_W-1:0]   tog_s3;
    logic                pt_ready_prev;
    logic                ack_tog;
  } main_state_t;

endpackage

// File: verif/rf_reader_model.sv
/*
  RF reader model: RF configuration writes and RF event pulses on rf_clock.
  Assumes the bench supplies rf_clock and the bank answers with rf_req_ready.
*/
`timescale 1ns/100ps
`default_nettype none
module rf_reader_model (
  // Link side
  input  wire logic                    rf_clock,
  input  wire logic                    rf_req_ready,
  output var  tag_cfg_pkg::rf_req_t    rf_req,
  output var  tag_cfg_pkg::rf_events_t rf_ev
);
  import tag_cfg_pkg::*;
  // ****************************************
  // Requests and events
  // ****************************************
  initial begin
    rf_req = '0;
    rf_ev  = '0;
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] d, output logic ok);
    int n;
    ok = 1'b0;
    @(posedge rf_clock);
    #1;
    rf_req = '{valid: 1'b1, addr: a, wdata: d};
    for (n = 0; n < 40; n++) begin
      @(posedge rf_clock);
      if (rf_req_ready === 1'b1) break;
    end
    #1;
    rf_req.valid = 1'b0;
    // Released data shows the inverse so a stale value cannot pass
    rf_req.wdata = ~d;
    for (n = 0; n < 40 && !ok; n++) begin
      @(posedge rf_clock);
      ok = (rf_req_ready === 1'b1);
    end
  endtask
  // Pulses keep the spacing the bank needs; page stays put meanwhile
  task automatic pulse(input int k, input logic [8:0] pg);
    @(posedge rf_clock);
    #1;
    rf_ev.read_page = pg;
    case (k)
      1: rf_ev.soc = 1'b1;
      2: rf_ev.select = 1'b1;
      3: rf_ev.read = 1'b1;
      4: rf_ev.pt_read_done = 1'b1;
      default: rf_ev.halt = 1'b1;
    endcase
    @(posedge rf_clock);
    #1;
    {rf_ev.soc, rf_ev.select, rf_ev.read, rf_ev.pt_read_done, rf_ev.halt} = 5'h00;
    repeat (5) @(posedge rf_clock);
  endtask
  task automatic field(input logic on);
    @(posedge rf_clock);
    #1;
    rf_ev.field_on = on;
    repeat (4) @(posedge rf_clock);
  endtask
endmodule // rf_reader_model
`default_nettype wire

// File: verif/tag_config_register_bank_tb_top.sv
/*
  Bench of the tag configuration bank: host port driven here, RF side by the reader model.
  Assumes the package, the defines header and the design are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tag_config_register_bank_tb_top;
  import tag_cfg_pkg::*;
  logic         clock = 1'b0;
  logic         rf_clock = 1'b0;
  logic         srst = 1'b1;
  host_req_t    host_req = '0;
  host_events_t host_ev = '0;
  rf_req_t      rf_req;
  rf_events_t   rf_ev;
  logic         rsp_valid, rf_ready, fd_out, fd_oe_n, pt_en, dir, mir_en, cs_en, refused;
  logic [7:0]   rsp_data, mir_base, rd;
  logic [15:0]  wdt;
  logic         fd_pin;
  logic [7:0]   rst_tab [7] = '{8'h01, 8'h00, 8'hf8, 8'h48, 8'h08, 8'h01, 8'h00};
  logic [7:0]   cfg_exp [7];
  int           bad_count = 0;
  int           num_checks = 0;
  int           seed = 32'h73f8;
  always #5 clock = ~clock;
  // Odd offset keeps the link clock off the host clock edges
  initial begin
    #2.3;
    forever #15 rf_clock = ~rf_clock;
  end
  // Open-drain pin with pull-up
  assign fd_pin = fd_oe_n ? 1'b1 : fd_out;
  tag_config_register_bank #(.LAST_BLOCK_MAX(55)) u_dut (
    .clock(clock), .srst(srst), .host_req(host_req), .host_rsp_valid(rsp_valid),
    .host_rsp_data(rsp_data), .host_ev(host_ev), .rf_clock(rf_clock), .rf_srst(srst),
    .rf_req(rf_req), .rf_req_ready(rf_ready), .rf_ev(rf_ev), .field_detect_in(fd_pin),
    .field_detect_output(fd_out), .field_detect_oe_n(fd_oe_n), .passthrough_enable(pt_en),
    .transfer_dir(dir), .mirror_enable(mir_en), .mirror_base_block(mir_base),
    .watchdog_time(wdt), .clock_stretch_enable(cs_en), .rf_mem_write_refused(refused));
  rf_reader_model u_rf (.rf_clock(rf_clock), .rf_req_ready(rf_ready), .rf_req(rf_req),
    .rf_ev(rf_ev));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic hop(input logic w, input logic s, input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    host_req = '{valid: 1'b1, write: w, session: s, addr: a, wdata: d};
    @(posedge clock);
    #1;
    host_req.valid = 1'b0;
    chk("rsp_valid", rsp_valid, 1'b1);
    rd = rsp_data;
  endtask
  task automatic rdc(input string n, input logic s, input logic [2:0] a, input logic [7:0] e);
    hop(1'b0, s, a, 8'h00);
    chk(n, rd, e);
  endtask
  task automatic wait_fd(input logic e);
    int n;
    for (n = 0; n < 40 && fd_oe_n !== e; n++) @(posedge clock);
    #1;
    chk("fd_oe_n", fd_oe_n, e);
    if (fd_oe_n !== e) stop_test;
  endtask
  task automatic rfw(input logic [2:0] a, input logic [7:0] d);
    logic ok;
    u_rf.wr(a, d, ok);
    chk("rf_ready", ok, 1'b1);
    if (!ok) stop_test;
  endtask
  // Data-ready stays as a level; the two last-data strobes last one cycle
  task automatic hev(input logic [2:0] v);
    @(posedge clock);
    #1;
    host_ev = host_events_t'(v);
    @(posedge clock);
    #1;
    host_ev.pt_last_read = 1'b0;
    host_ev.pt_last_written = 1'b0;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] b, lo, hi;
    logic [2:0] a;
    int i;
    cfg_exp = rst_tab;
    repeat (3) @(posedge clock);
    #1;
    srst = 1'b0;
    repeat (3) @(posedge clock);
    for (i = 0; i < 7; i++) begin
      rdc("cfg_rst", 1'b0, 3'(i), rst_tab[i]);
      if (i < 5) rdc("ses_rst", 1'b1, 3'(i), rst_tab[i]);
    end
    chk("dir", dir, 1'b1);
    chk("wdt", wdt, 16'h0848);
    chk("stretch", cs_en, 1'b1);
    chk("mirror_en", mir_en, 1'b0);
    chk("pt_en", pt_en, 1'b0);
    $display("test reset done");
    for (i = 0; i < 6; i++) begin
      a = 3'(1 + i % 2);
      b = 8'($random(seed));
      hop(1'b1, 1'b0, a, b);
      cfg_exp[a] = b;
      rdc("cfg_wr", 1'b0, a, b);
      rdc("ses_kept", 1'b1, a, rst_tab[a]);
    end
    b = 8'h01 + {3'h0, 5'($random(seed))};
    hop(1'b1, 1'b1, 3'h2, b);
    hop(1'b1, 1'b1, 3'h0, 8'h03);
    repeat (2) @(posedge clock);
    chk("mirror_base", mir_base, b);
    chk("mirror_en", mir_en, 1'b1);
    hop(1'b1, 1'b1, 3'h0, 8'h01);
    repeat (2) @(posedge clock);
    chk("mirror_off", mir_en, 1'b0);
    lo = 8'($random(seed));
    hi = 8'($random(seed));
    hop(1'b1, 1'b1, 3'h3, lo);
    repeat (2) @(posedge clock);
    chk("wdt_low_only", wdt, 16'h0848);
    hop(1'b1, 1'b1, 3'h4, hi);
    repeat (2) @(posedge clock);
    chk("wdt_loaded", wdt, {hi, lo});
    hop(1'b1, 1'b0, 3'h5, 8'h00);
    rdc("stretch_cfg", 1'b0, 3'h5, 8'h00);
    hop(1'b1, 1'b1, 3'h5, 8'h00);
    rdc("stretch_ses", 1'b1, 3'h5, 8'h01);
    chk("stretch_on", cs_en, 1'b1);
    $display("test registers done");
    for (i = 0; i < 3; i++) begin
      u_rf.field(1'b0);
      hop(1'b1, 1'b1, 3'h0, {2'b00, 2'(i == 1), 2'(i), 2'b01});
      wait_fd(1'b1);
      if (i > 0) begin
        u_rf.field(1'b1);
        repeat (8) @(posedge clock);
        #1;
        chk("fd_hold", fd_oe_n, 1'b1);
        u_rf.pulse(i, 9'h000);
      end else u_rf.field(1'b1);
      wait_fd(1'b0);
      rdc("status_low", 1'b1, 3'h6, 8'h01);
      if (i == 1) u_rf.pulse(5, 9'h000);
      else u_rf.field(1'b0);
      wait_fd(1'b1);
    end
    $display("test assert modes done");
    b = 8'h01 + {3'h0, 5'($random(seed))};
    hop(1'b1, 1'b1, 3'h1, b);
    hop(1'b1, 1'b1, 3'h0, 8'h21);
    u_rf.field(1'b1);
    wait_fd(1'b0);
    u_rf.pulse(3, {b[6:0], 2'b10});
    repeat (10) @(posedge clock);
    rdc("msg_early", 1'b1, 3'h6, 8'h01);
    u_rf.pulse(3, {b[6:0], 2'b11});
    wait_fd(1'b1);
    rdc("msg_set", 1'b1, 3'h6, 8'hc1);
    rdc("msg_clr", 1'b1, 3'h6, 8'h41);
    $display("test last message done");
    u_rf.field(1'b0);
    hop(1'b1, 1'b1, 3'h0, 8'h7d);
    u_rf.field(1'b1);
    hev(3'b100);
    wait_fd(1'b0);
    chk("pt_en", pt_en, 1'b1);
    hev(3'b010);
    wait_fd(1'b1);
    hop(1'b1, 1'b1, 3'h0, 8'h7c);
    u_rf.pulse(4, 9'h000);
    wait_fd(1'b0);
    hev(3'b001);
    wait_fd(1'b1);
    chk("dir_host_to_rf", dir, 1'b0);
    chk("rf_refused", refused, 1'b1);
    hop(1'b1, 1'b1, 3'h0, 8'h01);
    u_rf.field(1'b0);
    $display("test pass-through done");
    hop(1'b1, 1'b0, 3'h6, 8'h02);
    hop(1'b1, 1'b0, 3'h1, ~cfg_exp[1]);
    rdc("host_locked", 1'b0, 3'h1, cfg_exp[1]);
    rfw(3'h6, 8'h00);
    rdc("lock_sticky", 1'b0, 3'h6, 8'h02);
    rfw(3'h2, 8'h11);
    rdc("rf_write", 1'b0, 3'h2, 8'h11);
    rfw(3'h6, 8'h01);
    rdc("rf_lock", 1'b0, 3'h6, 8'h03);
    rfw(3'h2, 8'h22);
    rdc("rf_locked", 1'b0, 3'h2, 8'h11);
    $display("test locks done");
    @(posedge clock);
    #1;
    srst = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    srst = 1'b0;
    repeat (3) @(posedge clock);
    rdc("lock_rst", 1'b0, 3'h6, 8'h00);
    rdc("ses_last_rst", 1'b1, 3'h1, 8'h00);
    chk("mirror_rst", mir_base, 8'hf8);
    chk("wdt_rst", wdt, 16'h0848);
    rfw(3'h2, 8'h33);
    rdc("rf_unlocked", 1'b0, 3'h2, 8'h33);
    $display("test second reset done");
    stop_test;
  end
endmodule // tag_config_register_bank_tb_top
`default_nettype wire
